/* pdr_consts.svh */
// offsets, field positions, reset values and timing constants for the bank
`ifndef PDR_CONSTS_SVH
`define PDR_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PDR_OFS_DISCHARGE      8'h06
`define PDR_OFS_OVP            8'h07
`define PDR_OFS_RESERVED       8'h08
`define PDR_OFS_DELAY_CH3_CH2  8'h09

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PDR_BIT_CH10_PD        5
`define PDR_BIT_CH5_PD         4
`define PDR_BIT_CH4_PD         3
`define PDR_BIT_CH3_PD         2
`define PDR_OVP_MSB            2
`define PDR_DLY_CH3_MSB        7
`define PDR_DLY_CH3_LSB        4
`define PDR_DLY_CH2_MSB        3
`define PDR_DLY_CH2_LSB        0

// ----------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------
`define PDR_RST_DISCHARGE      8'h1c
`define PDR_MASK_DISCHARGE     8'h3c
`define PDR_RST_OVP            8'h06
`define PDR_MASK_OVP           8'h07

// ----------------------------------------------------------------
// threshold decode and timing
// ----------------------------------------------------------------
`define PDR_OVP_BASE_V         5'h08
`define PDR_OVP_TOP_CODE       3'h7
`define PDR_OVP_TOP_V          5'h19
`define PDR_DLY_STEP_MS        2
`define PDR_CLK_KHZ            200000
`define PDR_DLY_STEP_CYC       (`PDR_DLY_STEP_MS * `PDR_CLK_KHZ)

`endif

/* pdr_pkg.sv */
// types shared by the discharge, threshold and delay register bank
package pdr_pkg;

	// delay channel sequencing state
	typedef enum logic [1:0] {
		PDR_DLY_OFF,
		PDR_DLY_WAIT,
		PDR_DLY_ON
	} pdr_dly_state_t;

	typedef logic [3:0] pdr_dly_code_t;

endpackage

/* pdr_turn_on_delay.sv */
// turn-on delay of one converter channel, code times one step
`timescale 1ns/1ps
`default_nettype none
`include "pdr_consts.svh"

module pdr_turn_on_delay #(
	parameter int unsigned STEP_CYC = `PDR_DLY_STEP_CYC
) (
	// clock and reset
	input  wire logic              clk_i,
	input  wire logic              rstn_i,
	// request and code
	input  wire logic              enable_req_i,
	input  wire pdr_pkg::pdr_dly_code_t delay_code_i,
	// delayed enable
	output var  logic              enable_o
);

	pdr_pkg::pdr_dly_state_t state_r, state_nxt;
	logic [18:0]             step_cnt_r, step_cnt_nxt;
	pdr_pkg::pdr_dly_code_t  steps_r, steps_nxt;
	logic                    enable_r, enable_nxt;

	// next state: code 0 enables on the second edge after the request
	always_comb
	begin
		state_nxt    = state_r;
		step_cnt_nxt = step_cnt_r;
		steps_nxt    = steps_r;
		enable_nxt   = 1'b0;
		case (state_r)
			pdr_pkg::PDR_DLY_OFF:
			begin
				step_cnt_nxt = '0;
				steps_nxt    = delay_code_i;
				if (enable_req_i)
					state_nxt = pdr_pkg::PDR_DLY_WAIT;
			end
			pdr_pkg::PDR_DLY_WAIT:
			begin
				if (!enable_req_i)
					state_nxt = pdr_pkg::PDR_DLY_OFF;
				else if (steps_r == '0)
				begin
					state_nxt  = pdr_pkg::PDR_DLY_ON;
					enable_nxt = 1'b1;
				end
				else if (step_cnt_r == 19'(STEP_CYC - 1))
				begin
					step_cnt_nxt = '0;
					steps_nxt    = steps_r - 4'h1; // one 2 ms step done
				end
				else
					step_cnt_nxt = step_cnt_r + 19'h1;
			end
			pdr_pkg::PDR_DLY_ON:
			begin
				enable_nxt = enable_req_i;
				if (!enable_req_i)
					state_nxt = pdr_pkg::PDR_DLY_OFF;
			end
			default:
				state_nxt = pdr_pkg::PDR_DLY_OFF;
		endcase
	end

	// registers
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state_r    <= pdr_pkg::PDR_DLY_OFF;
			step_cnt_r <= '0;
			steps_r    <= '0;
			enable_r   <= 1'b0;
		end
		else
		begin
			state_r    <= state_nxt;
			step_cnt_r <= step_cnt_nxt;
			steps_r    <= steps_nxt;
			enable_r   <= enable_nxt;
		end
	end

	assign enable_o = enable_r;

endmodule // pdr_turn_on_delay

`default_nettype wire

/* pdr_regs.sv */
// discharge, overvoltage threshold and turn-on delay register bank
//
// Functional notes
// RQ1: ch10 bit set pulls ch10 output node down while ch10 is off.
// RQ2: ch5 bit set discharges ch5 output node while ch5 is off.
// RQ3: ch4 and ch3 bits act alike and reset to one.
// RQ4: threshold codes 0 to 6 give 8 V to 20 V, code 7 gives 25 V.
// RQ5: upper nibble of 0x09 delays ch3 enable by code times 2 ms.
// RQ6: lower nibble of 0x09 delays ch2 enable by code times 2 ms.
`timescale 1ns/1ps
`default_nettype none
`include "pdr_consts.svh"

module pdr_regs #(
	parameter int unsigned STEP_CYC          = `PDR_DLY_STEP_CYC,
	parameter logic [31:0] SEQ_DELAY_DEFAULT = 32'h0000_0000
) (
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	// register port from the serial slave
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	output var  logic [7:0] reg_rdata_o,
	// sequence profile strap
	input  wire logic [1:0] sequence_profile_select_i,
	// channel state
	input  wire logic       ch10_on_i,
	input  wire logic       ch5_on_i,
	input  wire logic       ch4_on_i,
	input  wire logic       ch3_on_i,
	input  wire logic       ch3_enable_req_i,
	input  wire logic       ch2_enable_req_i,
	// controls to the converters
	output var  logic       ch10_output_node_pulldown_o,
	output var  logic       ch5_output_node_pulldown_o,
	output var  logic       ch4_output_node_pulldown_o,
	output var  logic       ch3_output_node_pulldown_o,
	output var  logic [4:0] led_boost_overvoltage_volts_o,
	output var  logic       ch3_enable_o,
	output var  logic       ch2_enable_o
);

	// ----------------------------------------------------------------
	// decode helpers
	// ----------------------------------------------------------------
	// threshold code to volts: 2 V steps from 8 V, top code jumps
	function automatic logic [4:0] ovp_volts(input logic [2:0] code);
		if (code == `PDR_OVP_TOP_CODE)
			ovp_volts = `PDR_OVP_TOP_V; // RQ4
		else
			ovp_volts = `PDR_OVP_BASE_V + {1'b0, code, 1'b0}; // RQ4
	endfunction

	// one byte of the default table per sequence profile
	function automatic logic [7:0] seq_default(input logic [1:0] sel);
		seq_default = SEQ_DELAY_DEFAULT[{sel, 3'h0} +: 8];
	endfunction

	// one-hot register select: discharge, threshold, reserved, delay
	function automatic logic [3:0] reg_sel(input logic [7:0] addr);
		if (addr == `PDR_OFS_DISCHARGE)
			reg_sel = 4'h1;
		else if (addr == `PDR_OFS_OVP)
			reg_sel = 4'h2;
		else if (addr == `PDR_OFS_RESERVED)
			reg_sel = 4'h4; // reserved: reads zero, writes dropped
		else if (addr == `PDR_OFS_DELAY_CH3_CH2)
			reg_sel = 4'h8;
		else
			reg_sel = 4'h0;
	endfunction

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	// shadow registers of the bank
	logic [7:0] discharge_r, discharge_nxt;
	logic [7:0] ovp_r, ovp_nxt;
	logic [7:0] delay_r, delay_nxt;
	logic       strap_pend_r, strap_pend_nxt;
	// registered outputs
	logic [7:0] rdata_r, rdata_nxt;
	logic [3:0] pd_r, pd_nxt;
	logic [4:0] ovp_v_r, ovp_v_nxt;
	// one-hot offset decode
	logic [3:0] addr_sel;

	// ----------------------------------------------------------------
	// write and read port
	// ----------------------------------------------------------------
	// one decode of the offset serves both the write and the read path
	assign addr_sel = reg_sel(reg_addr_i);

	// writes, strap load and read mux
	always_comb
	begin
		discharge_nxt  = discharge_r;
		ovp_nxt        = ovp_r;
		delay_nxt      = delay_r;
		strap_pend_nxt = 1'b0;
		rdata_nxt      = 8'h00;
		// delay defaults load from the profile strap once, in the first cycle after reset release
		if (strap_pend_r)
			delay_nxt = seq_default(sequence_profile_select_i);
		// a write in the strap load cycle comes later and so wins
		if (reg_wr_i)
		begin
			if (addr_sel[0])
				discharge_nxt = reg_wdata_i & `PDR_MASK_DISCHARGE;
			else if (addr_sel[1])
				ovp_nxt = reg_wdata_i & `PDR_MASK_OVP;
			else if (addr_sel[3])
				delay_nxt = reg_wdata_i; // RQ5 RQ6
		end
		// reserved offset and unmapped offsets read back as zero
		if (addr_sel[0])
			rdata_nxt = discharge_r;
		else if (addr_sel[1])
			rdata_nxt = ovp_r;
		else if (addr_sel[3])
			rdata_nxt = delay_r;
		else
			rdata_nxt = 8'h00;
	end

	// ----------------------------------------------------------------
	// controls to the converters
	// ----------------------------------------------------------------
	// the pulldown is a level, held for as long as the channel is off,
	// so a node left charged by a slow turn-off still drains; the
	// threshold is handed over in volts so the comparator needs no table
	// pulldown only while the channel is off and its bit is set
	always_comb
	begin
		pd_nxt[3] = discharge_r[`PDR_BIT_CH10_PD] & ~ch10_on_i; // RQ1
		pd_nxt[2] = discharge_r[`PDR_BIT_CH5_PD] & ~ch5_on_i; // RQ2
		pd_nxt[1] = discharge_r[`PDR_BIT_CH4_PD] & ~ch4_on_i; // RQ3
		pd_nxt[0] = discharge_r[`PDR_BIT_CH3_PD] & ~ch3_on_i; // RQ3
		ovp_v_nxt = ovp_volts(ovp_r[`PDR_OVP_MSB:0]); // RQ4
	end

	// ----------------------------------------------------------------
	// state registers
	// ----------------------------------------------------------------
	// registers
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			discharge_r  <= `PDR_RST_DISCHARGE; // RQ3
			ovp_r        <= `PDR_RST_OVP;
			delay_r      <= 8'h00;
			strap_pend_r <= 1'b1;
			rdata_r      <= 8'h00;
			pd_r         <= 4'h0;
			ovp_v_r      <= 5'h00;
		end
		else
		begin
			discharge_r  <= discharge_nxt;
			ovp_r        <= ovp_nxt;
			delay_r      <= delay_nxt;
			strap_pend_r <= strap_pend_nxt;
			rdata_r      <= rdata_nxt;
			pd_r         <= pd_nxt;
			ovp_v_r      <= ovp_v_nxt;
		end
	end

	// ----------------------------------------------------------------
	// turn-on delay timers
	// ----------------------------------------------------------------
	logic [1:0] dly_req;
	logic [1:0] dly_en;
	logic [7:0] dly_codes;

	assign dly_req   = {ch3_enable_req_i, ch2_enable_req_i};
	assign dly_codes = delay_r;

	// each timer latches its code when its request rises; a write to
	// the delay register while a channel waits only affects the next
	// power-up of that channel
	// index 1 is ch3 upper nibble, index 0 is ch2 lower nibble
	generate
		for (genvar g = 0; g < 2; g++)
		begin : g_dly
			pdr_turn_on_delay #(
				.STEP_CYC     (STEP_CYC)
			) u_dly (
				.clk_i        (clk_i),
				.rstn_i       (rstn_i),
				.enable_req_i (dly_req[g]),
				.delay_code_i (dly_codes[g*4 +: 4]), // RQ5 RQ6
				.enable_o     (dly_en[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// every output is the q of a register above or in a timer
	assign reg_rdata_o                   = rdata_r;
	assign ch10_output_node_pulldown_o   = pd_r[3];
	assign ch5_output_node_pulldown_o    = pd_r[2];
	assign ch4_output_node_pulldown_o    = pd_r[1];
	assign ch3_output_node_pulldown_o    = pd_r[0];
	assign led_boost_overvoltage_volts_o = ovp_v_r;
	assign ch3_enable_o                  = dly_en[1];
	assign ch2_enable_o                  = dly_en[0];

endmodule // pdr_regs

`default_nettype wire

/* pdr_regs_monitor.sv */
// port checker for the discharge, threshold and delay bank
`timescale 1ns/1ps
`default_nettype none
module pdr_regs_monitor (
	// clock, reset and register port
	input wire logic       clk_i,
	input wire logic       rstn_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic       reg_wr_i,
	// channel state and requests
	input wire logic       ch10_on_i,
	input wire logic       ch5_on_i,
	input wire logic       ch4_on_i,
	input wire logic       ch3_on_i,
	input wire logic       ch3_enable_req_i,
	input wire logic       ch2_enable_req_i,
	// controls
	input wire logic       ch10_output_node_pulldown_o,
	input wire logic       ch5_output_node_pulldown_o,
	input wire logic       ch4_output_node_pulldown_o,
	input wire logic       ch3_output_node_pulldown_o,
	input wire logic [4:0] led_boost_overvoltage_volts_o,
	input wire logic       ch3_enable_o,
	input wire logic       ch2_enable_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_ovp_write;
		logic [2:0] c;
		(reg_wr_i && reg_addr_i == 8'h07, c = reg_wdata_i[2:0])
		##1 !(reg_wr_i && reg_addr_i == 8'h07) |-> ##1
		led_boost_overvoltage_volts_o == ((c == 3'h7) ? 5'h19 : 5'h08 + 2 * c);
	endproperty
	a_ch10_on_idle: assert property (
		ch10_on_i |=> !ch10_output_node_pulldown_o)
		else $error("ch10 pulled down while on");
	a_ch5_on_idle: assert property (
		ch5_on_i |=> !ch5_output_node_pulldown_o)
		else $error("ch5 pulled down while on");
	a_ch4_on_idle: assert property (
		ch4_on_i |=> !ch4_output_node_pulldown_o)
		else $error("ch4 pulled down while on");
	a_ch3_on_idle: assert property (
		ch3_on_i |=> !ch3_output_node_pulldown_o)
		else $error("ch3 pulled down while on");
	a_ovp_code_decode: assert property (p_ovp_write)
		else $error("threshold volts wrong after write");
	a_ch3_req_drop: assert property (
		!ch3_enable_req_i |=> !ch3_enable_o)
		else $error("ch3 enable stayed after request fell");
	a_ch3_rise_cause: assert property (
		$rose(ch3_enable_o) |-> $past(ch3_enable_req_i, 2))
		else $error("ch3 enable rose without request");
	a_ch2_req_drop: assert property (
		!ch2_enable_req_i |=> !ch2_enable_o)
		else $error("ch2 enable stayed after request fell");
	a_ch2_rise_cause: assert property (
		$rose(ch2_enable_o) |-> $past(ch2_enable_req_i, 2))
		else $error("ch2 enable rose without request");
	c_ch10_pull: cover property ($rose(ch10_output_node_pulldown_o));
	c_ch3_on: cover property ($rose(ch3_enable_o));
	c_ch2_on: cover property ($rose(ch2_enable_o));
	c_ovp_top: cover property (led_boost_overvoltage_volts_o == 5'h19);
endmodule // pdr_regs_monitor
`default_nettype wire

/* pdr_regs_test.sv */
// self-checking bench for the discharge, threshold and delay bank
`timescale 1ns/1ps
`default_nettype none
module pdr_regs_test;
	logic       clk_i = 1'b0;
	logic       rstn_i = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic       wr = 1'b0;
	logic [7:0] rdata;
	logic [3:0] on = 4'h0;
	logic [1:0] req = 2'h0;
	logic [1:0] strap = 2'h2;
	// default delay byte per profile, values arbitrary for the test
	localparam logic [31:0] SEQ_TABLE = 32'h3c5a_9600;
	logic [3:0] pd;
	logic [4:0] volts;
	logic [1:0] en;
	int         miscompares = 0;
	int         total_checks = 0;
	// 200 MHz clock
	always #2.5 clk_i = ~clk_i;
	pdr_regs #(.STEP_CYC(4), .SEQ_DELAY_DEFAULT(SEQ_TABLE)) dut_u (
		.clk_i(clk_i), .rstn_i(rstn_i),
		.reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
		.reg_rdata_o(rdata), .sequence_profile_select_i(strap),
		.ch10_on_i(on[3]), .ch5_on_i(on[2]), .ch4_on_i(on[1]),
		.ch3_on_i(on[0]), .ch3_enable_req_i(req[1]),
		.ch2_enable_req_i(req[0]), .ch10_output_node_pulldown_o(pd[3]),
		.ch5_output_node_pulldown_o(pd[2]), .ch4_output_node_pulldown_o(pd[1]),
		.ch3_output_node_pulldown_o(pd[0]),
		.led_boost_overvoltage_volts_o(volts),
		.ch3_enable_o(en[1]), .ch2_enable_o(en[0]));
	// ----------------------------------------------------------------
	// tasks, all entered and left at a falling edge
	// ----------------------------------------------------------------
	task automatic chk(string nm, logic [7:0] got, logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr_reg(logic [7:0] a, logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk_i);
		wr = 1'b0;
	endtask
	task automatic rd_reg(logic [7:0] a, logic [7:0] exp);
		addr = a;
		@(negedge clk_i);
		chk("rdata", rdata, exp);
	endtask
	task automatic t_reset();
		rd_reg(8'h06, 8'h1c);
		chk("pd", 8'(pd), 8'h07);
		rd_reg(8'h07, 8'h06);
		chk("volts", 8'(volts), 8'h14);
		wr_reg(8'h08, 8'hff);
		rd_reg(8'h08, 8'h00);
		rd_reg(8'h09, SEQ_TABLE[23:16]);
		strap = 2'h1;
		rd_reg(8'h09, SEQ_TABLE[23:16]);
	endtask
	task automatic t_pd();
		wr_reg(8'h06, 8'hff);
		rd_reg(8'h06, 8'h3c);
		chk("pd", 8'(pd), 8'h0f);
		on = 4'hf;
		@(negedge clk_i);
		chk("pd", 8'(pd), 8'h00);
		on = 4'h0;
		wr_reg(8'h06, 8'h24);
		rd_reg(8'h06, 8'h24);
		chk("pd", 8'(pd), 8'h09);
	endtask
	task automatic t_ovp();
		for (int c = 0; c < 8; c++)
		begin
			wr_reg(8'h07, {5'h1f, 3'(c)});
			rd_reg(8'h07, {5'h00, 3'(c)});
			chk("volts", 8'(volts), 8'((c == 7) ? 25 : 8 + 2 * c));
		end
	endtask
	task automatic t_dly(int ch, int code);
		int n;
		n = 0;
		req[ch] = 1'b1;
		while (en[ch] !== 1'b1 && n < 100)
		begin
			@(negedge clk_i);
			n++;
		end
		chk("delay", 8'(n), 8'(2 + code * 4));
		req[ch] = 1'b0;
		@(negedge clk_i);
		chk("enable", 8'(en[ch]), 8'h00);
		@(negedge clk_i);
	endtask
	task automatic t_delay();
		wr_reg(8'h09, 8'h5f);
		rd_reg(8'h09, 8'h5f);
		t_dly(1, 5);
		t_dly(0, 15);
		wr_reg(8'h09, 8'h20);
		t_dly(1, 2);
		t_dly(0, 0);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (10) @(negedge clk_i);
		rstn_i = 1'b1;
		repeat (2) @(negedge clk_i);
		t_reset();
		t_pd();
		t_ovp();
		t_delay();
		end_of_test();
	end
	// watchdog
	initial
	begin
		#5000;
		miscompares++;
		end_of_test();
	end
endmodule // pdr_regs_test
bind pdr_regs pdr_regs_monitor mon_u (.*);
`default_nettype wire
